// *** src/rc_ident.v ***
// Purpose: RC rise-time measurement with a Wishbone register slave
// Assumes: Comparator output is asynchronous; pad tristate done outside
// Notes:   Control at 0x0, captured count at 0x4; other addresses read zero
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "rc_ident_defs.vh"

module rc_ident (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        cmp_above_i,
    output reg         pin_o,
    output reg         pin_oe_o,
    output reg         clock_req_o,
    output reg         measure_done_irq_o
);

    localparam [2:0] ST_RESET = 3'h0;
    localparam [2:0] ST_ARMED = 3'h1;
    localparam [2:0] ST_DISCH = 3'h2;
    localparam [2:0] ST_CHARGE = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;

    reg  [2:0]  state_r;
    reg         enable_r;
    reg         start_r;
    reg  [2:0]  sel_r;
    reg         tc_r;
    reg         done_r;
    reg         cyerr_r;
    reg  [15:0] cnt_r;
    reg  [15:0] data_r;
    reg  [7:0]  div_r;
    reg         sync1_r;
    reg         sync2_r;
    reg  [1:0]  hist_r;
    reg         filt_r;
    wire        wr_ctrl;
    wire        new_en;
    wire        new_st;
    wire [2:0]  new_sel;
    wire [7:0]  div_max;
    wire        tick;

    assign wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (wb_adr_i == `ADR_CTRL);
    assign new_en  = wb_sel_i[0] ? wb_dat_i[`BIT_ENABLE] : enable_r;
    assign new_st  = wb_sel_i[0] ? wb_dat_i[`BIT_START] : start_r;
    assign new_sel = wb_sel_i[1] ? wb_dat_i[`SEL_MSB:`SEL_LSB] : sel_r;

    // Select n divides main clock by 2^n; select 0 is full rate
    assign div_max = (8'h01 << sel_r) - 8'h01;
    assign tick    = (div_r == div_max);

    // Time base only runs outside reset/done to save power
    always @(posedge clk_i) begin
        if (rst_i || state_r == ST_RESET || state_r == ST_DONE || tick)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // Synchroniser, then three-sample glitch filter
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            hist_r  <= 2'h0;
            filt_r  <= 1'b0;
        end else begin
            sync1_r <= cmp_above_i;
            sync2_r <= sync1_r;
            hist_r  <= {hist_r[0], sync2_r};
            if (hist_r[1] == hist_r[0] && hist_r[0] == sync2_r)
                filt_r <= sync2_r;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r  <= ST_RESET;
            enable_r <= 1'b0;
            start_r  <= 1'b0;
            sel_r    <= 3'h0;
            tc_r     <= 1'b0;
            done_r   <= 1'b0;
            cyerr_r  <= 1'b0;
            cnt_r    <= `CNT_ZERO;
            data_r   <= `CNT_ZERO;
        end else begin
            if (wr_ctrl) begin
                enable_r <= new_en;
                start_r  <= new_st;
                sel_r    <= new_sel;
            end
            case (state_r)
                ST_RESET: begin
                    tc_r    <= 1'b0;
                    done_r  <= 1'b0;
                    cyerr_r <= 1'b0;
                    cnt_r   <= `CNT_ZERO;
                    if (wr_ctrl && new_en && !new_st)
                        state_r <= ST_ARMED;
                end
                ST_ARMED: begin
                    if (wr_ctrl && !new_en)
                        state_r <= ST_RESET;
                    else if (wr_ctrl && new_st) begin
                        state_r <= ST_DISCH;
                        cnt_r   <= `CNT_ZERO;
                    end
                end
                ST_DISCH: begin
                    if (wr_ctrl && !new_en)
                        state_r <= ST_RESET;
                    else if (tick) begin
                        if (cnt_r == `CNT_MAX) begin
                            tc_r    <= 1'b1;
                            if (filt_r)
                                cyerr_r <= 1'b1;
                            cnt_r   <= `CNT_ZERO;
                            state_r <= ST_CHARGE;
                        end else
                            cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_CHARGE: begin
                    if (wr_ctrl && !new_en)
                        state_r <= ST_RESET;
                    else if (filt_r) begin
                        data_r  <= cnt_r;
                        done_r  <= 1'b1;
                        state_r <= ST_DONE;
                    end else if (tick) begin
                        if (cnt_r == `CNT_MAX) begin
                            cyerr_r <= 1'b1;
                            data_r  <= cnt_r;
                            done_r  <= 1'b1;
                            state_r <= ST_DONE;
                        end else
                            cnt_r <= cnt_r + 16'h0001;
                    end
                end
                ST_DONE: begin
                    if (wr_ctrl && !new_en)
                        state_r <= ST_RESET;
                end
                default: state_r <= ST_RESET;
            endcase
        end
    end

    // Outputs registered from current state, so they lag state by one cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o              <= 1'b0;
            pin_oe_o           <= 1'b0;
            clock_req_o        <= 1'b0;
            measure_done_irq_o <= 1'b0;
        end else begin
            pin_o              <= 1'b0;
            pin_oe_o           <= (state_r == ST_DISCH);
            clock_req_o        <= (state_r == ST_ARMED) || (state_r == ST_DISCH)
                                  || (state_r == ST_CHARGE);
            measure_done_irq_o <= done_r;
        end
    end

    // One registered answer a cycle after each request; unmapped reads return zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
                if (wb_adr_i == `ADR_CTRL) begin
                    wb_dat_o[`BIT_ENABLE]          <= enable_r;
                    wb_dat_o[`BIT_START]           <= start_r;
                    wb_dat_o[`BIT_TC]              <= tc_r;
                    wb_dat_o[`BIT_DONE]            <= done_r;
                    wb_dat_o[`BIT_CYERR]           <= cyerr_r;
                    wb_dat_o[`SEL_MSB:`SEL_LSB]    <= sel_r;
                end else if (wb_adr_i == `ADR_DATA)
                    wb_dat_o[15:0] <= data_r;
            end
        end
    end

endmodule
`default_nettype wire

// *** pkg/rc_ident_defs.vh ***
// Purpose: Constants for the RC delay identification block
// Assumes: 20 MHz main clock, classic Wishbone register access
// Notes:   Functional notes below
`ifndef RC_IDENT_DEFS_VH
`define RC_IDENT_DEFS_VH

`define ADR_CTRL       4'h0
`define ADR_DATA       4'h4
`define BIT_ENABLE     0
`define BIT_START      1
`define BIT_TC         2
`define BIT_DONE       3
`define BIT_CYERR      4
`define SEL_LSB        8
`define SEL_MSB        10
`define CNT_MAX        16'hffff
`define CNT_ZERO       16'h0000
`define FILT_LEN       3
`define ARM_WAIT_US    300
`define CLK_MHZ        20

`endif

// *** verification/rc_ident_asserts.sv ***
// Purpose: Port checks for rc_ident
// Assumes: One clock, sync high reset
// Notes:   Select field tracked from writes
`timescale 1ns/100ps
`default_nettype none
module rc_ident_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        cmp_above_i,
    input wire logic        pin_o,
    input wire logic        pin_oe_o,
    input wire logic        clock_req_o,
    input wire logic        measure_done_irq_o
);
    logic [31:0] cnt_r;
    logic [2:0]  sel_r;
    logic        seen_r;
    wire logic   chg = seen_r && clock_req_o && !pin_oe_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always @(posedge clk_i) begin
        cnt_r <= pin_oe_o ? cnt_r + 32'h1 : 32'h0;
        seen_r <= !rst_i && clock_req_o && (seen_r || pin_oe_o);
        if (rst_i)
            sel_r <= 3'h0;
        else if (wb_ack_o && wb_we_i)
            sel_r <= wb_dat_i[10:8];
    end
    a_pin_low: assert property (pin_oe_o |-> !pin_o && clock_req_o)
        else $error("bad pin drive");
    a_start_opens: assert property ($rose(pin_oe_o) |-> $past(wb_cyc_i && wb_we_i && wb_dat_i[1:0] == 2'h3))
        else $error("discharge without start");
    a_dis_len: assert property ($fell(pin_oe_o) && !$past(wb_we_i) |->
        cnt_r + 32'h1 >= (32'h10000 << sel_r) && cnt_r <= (32'h10000 << sel_r) + 32'h1) else $error("discharge length");
    a_charge_stops: assert property (chg && cmp_above_i [*5] |-> ##[1:3] !clock_req_o)
        else $error("charge did not stop");
    a_done_quiet: assert property (measure_done_irq_o |-> !clock_req_o && !pin_oe_o)
        else $error("done not idle");
    a_irq_cause: assert property ($rose(measure_done_irq_o) |-> $past(seen_r, 2) || $past(seen_r, 3))
        else $error("irq without measurement");
    a_done_holds: assert property ($fell(measure_done_irq_o) |-> $past(wb_ack_o && wb_we_i, 2))
        else $error("done dropped alone");
    a_reset_idle: assert property ($fell(rst_i) |-> !pin_oe_o && !clock_req_o && !measure_done_irq_o)
        else $error("not idle after reset");
endmodule
bind rc_ident rc_ident_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_we_i, .wb_dat_i, .wb_ack_o,
    .cmp_above_i, .pin_o, .pin_oe_o, .clock_req_o, .measure_done_irq_o);
`default_nettype wire

// *** verification/rc_network.sv ***
// Purpose: Behavioural RC network with comparator
// Assumes: Discharge empties the capacitor in one cycle
// Notes:   Short spike mimics noise on the slow edge
`timescale 1ns/100ps
`default_nettype none
module rc_network #(parameter int RISE = 200, parameter int GLITCH = 100) (
    input wire logic clk_i,
    input wire logic pin_o,
    input wire logic pin_oe_o,
    output logic     cmp_above_o
);
    int lvl_r = RISE;
    always @(posedge clk_i) begin
        if (pin_oe_o && !pin_o)
            lvl_r <= 0;
        else if (lvl_r < RISE)
            lvl_r <= lvl_r + 1;
    end
    assign cmp_above_o = lvl_r >= RISE || (lvl_r >= GLITCH && lvl_r < GLITCH + 2);
endmodule
`default_nettype wire

// *** verification/rc_ident_tb_top.sv ***
// Purpose: Self-checking bench for rc_ident
// Assumes: Select 0, so discharge is 65536 cycles
// Notes:   Register rows first, then one measurement
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t mismatch", $time); end end
module rc_ident_tb_top;
    localparam int RISE = 200;
    typedef struct packed {logic we; logic [3:0] adr; logic [31:0] dat; logic [31:0] exp;} row_t;
    row_t        rows [5] = '{'{1'b0, 4'h0, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'h501, 32'h0},
        '{1'b0, 4'h0, 32'h0, 32'h501}, '{1'b0, 4'h8, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'h0, 32'h0}};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic        wb_ack_o, cmp_above_i, pin_o, pin_oe_o, clock_req_o, measure_done_irq_o;
    int          fails = 0;
    int          cmp_count = 0;
    int          i;
    rc_ident u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_above_i, .pin_o, .pin_oe_o, .clock_req_o, .measure_done_irq_o);
    rc_network #(.RISE(RISE), .GLITCH(100)) u_rc (.clk_i, .pin_o, .pin_oe_o, .cmp_above_o(cmp_above_i));
    initial forever #25 clk_i = ~clk_i;
    task automatic tally_and_finish;
        $display("Compared %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
            @(posedge clk_i);
        rd = wb_dat_o;
        if (i == 20) begin
            fails++;
            tally_and_finish();
        end
        wb_cyc_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[k]) begin
            wb_xfer(rows[k].we, rows[k].adr, rows[k].dat);
            if (!rows[k].we) `CHK(rd, rows[k].exp)
        end
        wb_xfer(1'b1, 4'h0, 32'h1);
        repeat (6000) @(posedge clk_i);
        `CHK({clock_req_o, pin_oe_o}, 2'b10)
        wb_xfer(1'b1, 4'h0, 32'h3);
        repeat (3) @(posedge clk_i);
        `CHK({pin_oe_o, pin_o}, 2'b10)
        for (i = 0; i < 80000 && measure_done_irq_o !== 1'b1; i++)
            @(posedge clk_i);
        repeat (20) @(posedge clk_i);
        `CHK(measure_done_irq_o, 1'b1)
        wb_xfer(1'b0, 4'h0, 32'h0);
        `CHK(rd[4:0], 5'h0f)
        wb_xfer(1'b0, 4'h4, 32'h0);
        `CHK(rd[15:0] >= RISE && rd[15:0] <= RISE + 10, 1'b1)
        wb_xfer(1'b1, 4'h0, 32'h0);
        wb_xfer(1'b0, 4'h0, 32'h0);
        `CHK(rd, 32'h0)
        wb_xfer(1'b1, 4'h0, 32'h1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, 4'h0, 32'h0);
        `CHK({rd, clock_req_o}, 33'h0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
